// >>> hw/tgw_top.sv
// Toggle watchdog for nibble processing and ID extension 1 write lock
`timescale 1ns/1ps
module tgw_top #(
    parameter int unsigned TIMEOUT_CYCLES = tgw_pkg::TIMEOUT_CYC
) (
    // Clock, reset, enable
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               ce_i,
    // Wishbone slave
    input  wire logic               cyc_i,
    input  wire logic               stb_i,
    input  wire logic               we_i,
    input  wire logic [3:0]         adr_i,
    input  wire logic [3:0]         sel_i,
    input  wire logic [31:0]        dat_i,
    output logic      [31:0]        dat_o,
    output logic                    ack_o,
    // Slave state from the protocol engine
    input  wire logic [4:0]         slave_addr_i,
    input  wire logic [3:0]         user_idext1_i,
    input  wire tgw_pkg::tgw_req_t  req_i,
    input  wire logic               req_valid_i,
    // Pin
    input  wire logic               param_port_zero_i,
    // Results
    output tgw_pkg::tgw_resp_t      resp_o,
    output logic                    wdog_reset_o,
    output logic                    outputs_clear_o,
    output logic                    data_strobe_o,
    output logic                    param_strobe_o,
    output logic                    dx_disable_o,
    output logic                    init_start_o,
    output logic                    irq_o
);
    import tgw_pkg::*;

    logic [15:0]      ctrl_q;
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_mask_q;
    logic             enabled_q;
    logic             prev_nib_q;
    logic             have_prev_q;
    logic             p0_s;
    logic             expire;
    logic             active;
    logic             kick;
    logic             dx;
    logic             locked;
    logic [3:0]       fcopy;
    logic [3:0]       rd_val;
    logic             wr_match;
    logic [IRQ_W-1:0] ev;
    logic             wb_hit;

    if (TIMEOUT_CYCLES < 2) begin : g_bad_timeout
        $error("TIMEOUT_CYCLES too small");
    end

    tgw_sync #(.W(1)) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (param_port_zero_i),
        .q_o   (p0_s)
    );

    assign dx     = req_valid_i && req_i.data_xchg;
    assign locked = ctrl_q[CTRL_LOCK];
    assign fcopy  = ctrl_q[CTRL_FCOPY_LSB +: 4];

    // Enable on first data output event, cleared by delete or reset
    always_ff @(posedge clk_i) begin
        if (rst_i || wdog_reset_o) begin
            enabled_q <= 1'b0;
        end else if (ce_i) begin
            if (req_valid_i && req_i.delete_addr) begin
                enabled_q <= 1'b0;
            end else if (dx && slave_addr_i != 5'h00) begin
                enabled_q <= 1'b1;
            end
        end
    end

    assign active = enabled_q
        && ctrl_q[CTRL_ID_LSB +: 4] == ID_CODE_4I4O && ctrl_q[CTRL_EXT_4I4O]
        && (ctrl_q[CTRL_WDOG_ACT] || (ctrl_q[CTRL_P0_ARM] && p0_s));

    // Toggle detection on processed exchanges
    always_ff @(posedge clk_i) begin
        if (rst_i || wdog_reset_o) begin
            prev_nib_q  <= 1'b0;
            have_prev_q <= 1'b0;
        end else if (ce_i && dx) begin
            prev_nib_q  <= req_i.data[2];
            have_prev_q <= 1'b1;
        end
    end

    assign kick = dx && (!have_prev_q || req_i.data[2] != prev_nib_q);

    // Expiry fires at the limit and the reset one cycle later; tolerance allows this slack
    tgw_timeout #(.LIMIT(TIMEOUT_CYCLES)) u_tmo (
        .clk_i    (clk_i),
        .rst_i    (rst_i || wdog_reset_o),
        .ce_i     (ce_i),
        .run_i    (active),
        .kick_i   (kick),
        .expire_o (expire)
    );

    // Unconditioned reset and its side effects, one-cycle pulses
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wdog_reset_o    <= 1'b0;
            outputs_clear_o <= 1'b0;
            data_strobe_o   <= 1'b0;
            param_strobe_o  <= 1'b0;
            init_start_o    <= 1'b0;
        end else if (ce_i) begin
            wdog_reset_o    <= expire && !wdog_reset_o;
            outputs_clear_o <= expire && !wdog_reset_o;
            data_strobe_o   <= expire && !wdog_reset_o;
            param_strobe_o  <= expire && !wdog_reset_o;
            init_start_o    <= expire && !wdog_reset_o;
        end
    end

    // Exchange disable set on expiry and held until reset; processed exchanges do not clear it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dx_disable_o <= 1'b0;
        end else if (ce_i) begin
            if (expire && !wdog_reset_o) begin
                dx_disable_o <= 1'b1;
            end else if (req_valid_i && req_i.write_idext1 == 1'b0 && dx) begin
                dx_disable_o <= dx_disable_o;
            end
        end
    end

    // Read answer construction
    always_comb begin
        if (locked) begin
            rd_val = fcopy;
            if (ctrl_q[CTRL_EXT_ADDR]) begin
                rd_val[AB_SEL_BIT] = user_idext1_i[AB_SEL_BIT];
            end
        end else begin
            rd_val = user_idext1_i;
        end
    end

    // Protected part excludes the selector bit under extended addressing
    assign wr_match = ctrl_q[CTRL_EXT_ADDR]
        ? (req_i.data[2:0] == fcopy[2:0])
        : (req_i.data == fcopy);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            resp_o <= '0;
        end else if (ce_i) begin
            resp_o <= '0;
            if (req_valid_i && req_i.read_idext1) begin
                resp_o.reply_valid <= 1'b1;
                resp_o.reply_data  <= rd_val;
            end else if (req_valid_i && req_i.write_idext1) begin
                if (!locked || wr_match) begin
                    resp_o.reply_valid <= 1'b1;
                    resp_o.reply_data  <= req_i.data;
                    resp_o.ee_write    <= 1'b1;
                    resp_o.ee_data     <= req_i.data;
                end // else
            end
        end
    end

    assign ev[IRQ_WDOG]      = ce_i && expire && !wdog_reset_o;
    assign ev[IRQ_WR_REJECT] = ce_i && req_valid_i && req_i.write_idext1 && locked && !wr_match;
    assign ev[IRQ_WR_ACCEPT] = ce_i && req_valid_i && req_i.write_idext1 && (!locked || wr_match);

    // Wishbone: one-cycle ack, writes take effect at the ack edge
    assign wb_hit = cyc_i && stb_i && !ack_o;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= wb_hit;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q     <= CTRL_RST;
            irq_mask_q <= '0;
        end else if (ack_o && we_i) begin
            if (adr_i == REG_CTRL) begin
                if (sel_i[0]) ctrl_q[7:0]  <= dat_i[7:0];
                if (sel_i[1]) ctrl_q[15:8] <= dat_i[15:8];
            end
            if (adr_i == REG_IRQ_MASK && sel_i[0]) begin
                irq_mask_q <= dat_i[IRQ_W-1:0];
            end
        end
    end

    // Set wins over write-one-to-clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_q <= '0;
        end else begin
            if (ack_o && we_i && adr_i == REG_IRQ_STAT && sel_i[0]) begin
                irq_stat_q <= (irq_stat_q & ~dat_i[IRQ_W-1:0]) | ev;
            end else begin
                irq_stat_q <= irq_stat_q | ev;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= '0;
        end else begin
            case (adr_i)
                REG_CTRL:     dat_o <= {16'h0000, ctrl_q};
                REG_STATUS:   dat_o <= {26'h0, dx_disable_o, p0_s, have_prev_q, prev_nib_q,
                                        active, enabled_q};
                REG_IRQ_STAT: dat_o <= {29'h0, irq_stat_q};
                REG_IRQ_MASK: dat_o <= {29'h0, irq_mask_q};
                default:      dat_o <= '0;
            endcase
        end
    end

    assign irq_o = |(irq_stat_q & irq_mask_q);

    // Checks
    a_enable_needs_addr: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(enabled_q) |-> $past(slave_addr_i) != 5'h00 && $past(dx))
        else $error("watchdog enabled without cause");
    a_delete_disables: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && req_valid_i && req_i.delete_addr |=> !enabled_q)
        else $error("delete did not disable watchdog");
    a_mode_gates_active: assert property (@(posedge clk_i) disable iff (rst_i)
        active |-> ctrl_q[CTRL_ID_LSB +: 4] == ID_CODE_4I4O && ctrl_q[CTRL_EXT_4I4O])
        else $error("active outside nibble mode");
    a_arm_gates_active: assert property (@(posedge clk_i) disable iff (rst_i)
        active |-> ctrl_q[CTRL_WDOG_ACT] || (ctrl_q[CTRL_P0_ARM] && p0_s))
        else $error("active without arm");
    a_reset_has_cause: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(wdog_reset_o) |-> $past(expire))
        else $error("watchdog reset without expiry");
    a_reset_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && wdog_reset_o |=> !wdog_reset_o)
        else $error("watchdog reset longer than one cycle");
    a_reset_effects: assert property (@(posedge clk_i) disable iff (rst_i)
        wdog_reset_o |-> data_strobe_o && param_strobe_o && outputs_clear_o && init_start_o
            ##1 dx_disable_o)
        else $error("reset effects missing");
    a_dx_disable_holds: assert property (@(posedge clk_i) disable iff (rst_i)
        dx_disable_o |=> dx_disable_o)
        else $error("exchange disable dropped");
    a_locked_read: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && req_valid_i && req_i.read_idext1 && locked && !ctrl_q[CTRL_EXT_ADDR]
        |=> resp_o.reply_data == $past(fcopy))
        else $error("locked read not from factory copy");
    a_locked_ab_bit: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && req_valid_i && req_i.read_idext1 && locked && ctrl_q[CTRL_EXT_ADDR]
        |=> resp_o.reply_data[3] == $past(user_idext1_i[3]))
        else $error("selector bit not from user value");
    a_reject_silent: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && req_valid_i && req_i.write_idext1 && locked && !wr_match
        |=> !resp_o.reply_valid && !resp_o.ee_write)
        else $error("mismatching write not ignored");
    a_locked_accept: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && req_valid_i && req_i.write_idext1 && locked && wr_match
        |=> resp_o.reply_valid && resp_o.ee_write)
        else $error("matching write not taken");
    a_unlocked_read: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && req_valid_i && req_i.read_idext1 && !locked
        |=> resp_o.reply_data == $past(user_idext1_i))
        else $error("unlocked read wrong");
    a_unlocked_write: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && req_valid_i && req_i.write_idext1 && !locked
        |=> resp_o.ee_write && resp_o.reply_valid)
        else $error("unlocked write not taken");
    a_unlocked_ee_data: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && req_valid_i && req_i.write_idext1 && !locked
        |=> resp_o.ee_data == $past(req_i.data))
        else $error("unlocked write data wrong");
    a_toggle_kicks: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && dx && have_prev_q && req_i.data[2] != prev_nib_q
        |=> u_tmo.cnt_q == '0)
        else $error("toggle did not restart timeout");

    c_wdog_fire: cover property (@(posedge clk_i) $rose(wdog_reset_o));
    c_reject: cover property (@(posedge clk_i) ev[IRQ_WR_REJECT]);
    c_accept_locked: cover property (@(posedge clk_i) ev[IRQ_WR_ACCEPT] && locked);
    c_locked_ab_read: cover property (@(posedge clk_i)
        req_valid_i && req_i.read_idext1 && locked && ctrl_q[CTRL_EXT_ADDR]);
    c_p0_armed: cover property (@(posedge clk_i) active && !ctrl_q[CTRL_WDOG_ACT]);
endmodule

// >>> hw/tgw_pkg.sv
// Package: constants and carriers of the toggle watchdog and ID-extension lock
package tgw_pkg;
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned TIMEOUT_MS      = 327;
    localparam int unsigned TIMEOUT_TOL_MS  = 16;
    localparam int unsigned TIMEOUT_CYC     = TIMEOUT_MS * (CLK_HZ / 1000);
    localparam logic [3:0]  ID_CODE_4I4O    = 4'ha;
    localparam int unsigned AB_SEL_BIT      = 3;
    // Register byte offsets
    localparam logic [3:0]  REG_CTRL        = 4'h0;
    localparam logic [3:0]  REG_STATUS      = 4'h4;
    localparam logic [3:0]  REG_IRQ_STAT    = 4'h8;
    localparam logic [3:0]  REG_IRQ_MASK    = 4'hc;
    // Control field positions
    localparam int unsigned CTRL_WDOG_ACT   = 0;
    localparam int unsigned CTRL_P0_ARM     = 1;
    localparam int unsigned CTRL_EXT_4I4O   = 2;
    localparam int unsigned CTRL_LOCK       = 3;
    localparam int unsigned CTRL_EXT_ADDR   = 4;
    localparam int unsigned CTRL_ID_LSB     = 8;
    localparam int unsigned CTRL_FCOPY_LSB  = 12;
    localparam logic [15:0] CTRL_RST        = 16'h0000;
    // Interrupt event bits
    localparam int unsigned IRQ_WDOG        = 0;
    localparam int unsigned IRQ_WR_REJECT   = 1;
    localparam int unsigned IRQ_WR_ACCEPT   = 2;
    localparam int unsigned IRQ_W           = 3;

    // One processed master request as seen by the supervisor
    typedef struct packed {
        logic       data_xchg;
        logic       delete_addr;
        logic       read_idext1;
        logic       write_idext1;
        logic [3:0] data;
    } tgw_req_t;

    // Outcome toward the reply and EEPROM logic
    typedef struct packed {
        logic       reply_valid;
        logic [3:0] reply_data;
        logic       ee_write;
        logic [3:0] ee_data;
    } tgw_resp_t;
endpackage

// >>> hw/tgw_timeout.sv
// Timeout counter restarted by a kick pulse
`timescale 1ns/1ps
module tgw_timeout #(
    parameter int unsigned LIMIT = tgw_pkg::TIMEOUT_CYC
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    // Control
    input  wire logic run_i,
    input  wire logic kick_i,
    output logic      expire_o
);
    import tgw_pkg::*;
    localparam int unsigned CW = $clog2(LIMIT + 1);
    logic [CW-1:0] cnt_q;

    // Below two the expiry compare would see LIMIT - 1 right after every restart
    if (LIMIT < 2) begin : g_bad_limit
        $error("LIMIT too small");
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= '0;
        end else if (ce_i) begin
            if (!run_i || kick_i) begin
                cnt_q <= '0;
            end else if (cnt_q != CW'(LIMIT)) begin
                cnt_q <= cnt_q + CW'(1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            expire_o <= 1'b0;
        end else if (ce_i) begin
            expire_o <= run_i && !kick_i && (cnt_q == CW'(LIMIT - 1));
        end
    end
endmodule

// >>> hw/tgw_sync.sv
// Two-flop synchroniser for pin levels
`timescale 1ns/1ps
module tgw_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= '0;
            q_o    <= '0;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end
endmodule

// >>> testbench/tgw_master_model.sv
// Master model issuing processed requests into the supervisor
`timescale 1ns/1ps
module tgw_master_model (
    input  wire logic                clk_i,
    output tgw_pkg::tgw_req_t        req_o,
    output logic                     req_valid_o,
    input  wire tgw_pkg::tgw_resp_t  resp_i
);
    import tgw_pkg::*;
    initial begin
        req_o = '0;
        req_valid_o = 1'b0;
    end
    // One request; gap gives a slow master
    task automatic send(input tgw_req_t r, input int gap, output tgw_resp_t rsp);
        repeat (gap) @(posedge clk_i);
        req_o <= r;
        req_valid_o <= 1'b1;
        @(posedge clk_i);
        req_valid_o <= 1'b0;
        // Released payload must not echo the last one
        req_o <= {4'h0, ~r.data};
        @(posedge clk_i);
        rsp = resp_i;
    endtask
    task automatic xchg(input logic nib, output tgw_resp_t rsp);
        send({4'b1000, 1'($urandom), nib, 2'($urandom)}, 0, rsp);
    endtask
    task automatic rd_id(output tgw_resp_t rsp);
        send({4'b0010, 4'h0}, 1, rsp);
    endtask
    task automatic wr_id(input logic [3:0] d, output tgw_resp_t rsp);
        send({4'b0001, d}, 0, rsp);
    endtask
    task automatic del(output tgw_resp_t rsp);
        send({4'b0100, 4'h0}, 0, rsp);
    endtask
    // Selector change keeps the low three bits as read
    task automatic flip_ab(output tgw_resp_t rsp);
        rd_id(rsp);
        wr_id({~rsp.reply_data[3], rsp.reply_data[2:0]}, rsp);
    endtask
endmodule

// >>> testbench/tb_toggle_watchdog_id_protect.sv
// Self-checking bench for the toggle watchdog and ID extension lock
`timescale 1ns/1ps
module tb_toggle_watchdog_id_protect;
    import tgw_pkg::*;
    localparam int T = 50;
    logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, p0 = 0;
    logic [3:0]  adr_i = '0, user = '0, sel = 4'hf;
    logic [4:0]  saddr = '0;
    logic [31:0] dat_i = '0, dat_o, rd;
    logic        ack_o, irq_o, wdr, oclr, dstb, pstb, dxd, init, reqv;
    tgw_req_t    req;
    tgw_resp_t   resp, r;
    int          err_total = 0, n_tests = 0, cyc = 0, wd_n = 0, wd_at = 0, kick, n;

    always #50 clk_i = ~clk_i;

    tgw_top #(.TIMEOUT_CYCLES(T)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .slave_addr_i(saddr), .user_idext1_i(user), .req_i(req),
        .req_valid_i(reqv), .param_port_zero_i(p0), .resp_o(resp), .wdog_reset_o(wdr),
        .outputs_clear_o(oclr), .data_strobe_o(dstb), .param_strobe_o(pstb),
        .dx_disable_o(dxd), .init_start_o(init), .irq_o(irq_o));
    tgw_master_model m (.clk_i(clk_i), .req_o(req), .req_valid_o(reqv), .resp_i(resp));

    // Non-blocking so readers at an edge see stable counts
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (wdr === 1'b1) begin
            wd_n <= wd_n + 1;
            wd_at <= cyc;
            chk({oclr, dstb, pstb, init}, 4'hf);
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("Counts: checks=%0d mismatches=%0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        for (i = 0; i < 20 && ack_o !== 1'b1; i++) @(posedge clk_i);
        if (i == 20) begin
            err_total++;
            stop_test();
        end else begin
            rd = dat_o;
            cyc_i <= 1'b0;
            stb_i <= 1'b0;
        end
    endtask
    task automatic do_reset;
        rst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask
    task automatic no_wd;
        int n0;
        n0 = wd_n;
        repeat (T + 10) @(posedge clk_i);
        chk(wd_n, n0);
    endtask
    // Expiry lies between T and a small tolerance after the last kick
    task automatic exp_wd(input int k);
        int n0, i;
        n0 = wd_n;
        for (i = 0; i < 2 * T && wd_n == n0; i++) @(posedge clk_i);
        chk(wd_n - n0, 1);
        if (wd_n == n0) begin
            stop_test();
        end else begin
            chk(wd_at - k >= T && wd_at - k <= T + 3, 1);
        end
    endtask
    function automatic logic [31:0] ctl(input logic [3:0] id, fc, input logic [4:0] f);
        return {16'h0, fc, id, 3'h0, f};
    endfunction

    initial begin
        #(100 * 60000);
        err_total++;
        stop_test();
    end

    initial begin
        logic [3:0] fc, u, wd;
        logic [4:0] f;
        logic       acc;
        int         i;
        void'($urandom(77304));
        do_reset();
        wb(0, REG_CTRL, 0);
        chk(rd, {16'h0, CTRL_RST});
        wb(0, 4'h2, 0);
        chk(rd, 0);
        $display("test registers done");
        for (i = 0; i < 16; i++) begin
            f = {1'($urandom), 1'($urandom), 3'h0};
            fc = 4'($urandom);
            u = 4'($urandom);
            wd = i[0] ? 4'($urandom) : {1'($urandom), fc[2:0]};
            wb(1, REG_CTRL, ctl(4'h0, fc, f));
            user <= u;
            m.rd_id(r);
            chk(r.reply_valid, 1);
            chk(r.reply_data, !f[3] ? u : f[4] ? {u[3], fc[2:0]} : fc);
            acc = !f[3] || (f[4] ? wd[2:0] == fc[2:0] : wd == fc);
            m.wr_id(wd, r);
            chk({r.reply_valid, r.ee_write, r.ee_data}, {acc, acc, acc ? wd : 4'h0});
        end
        wb(1, REG_CTRL, ctl(4'h0, 4'h5, 5'h18));
        user <= 4'h8;
        m.flip_ab(r);
        chk({r.reply_valid, r.ee_write, r.ee_data}, 6'h35);
        $display("test lock done");
        wb(1, REG_IRQ_STAT, 32'h7);
        wb(1, REG_IRQ_MASK, 32'h2);
        m.wr_id(4'h2, r);
        wb(0, REG_IRQ_STAT, 0);
        chk(rd, 32'h2);
        chk(irq_o, 1);
        wb(1, REG_IRQ_STAT, 32'h2);
        // Clear lands at the ack edge; look one edge later
        @(posedge clk_i);
        chk(irq_o, 0);
        wb(1, REG_IRQ_MASK, 32'h0);
        m.wr_id(4'h2, r);
        wb(0, REG_IRQ_STAT, 0);
        chk({rd[1:0], irq_o}, 3'h4);
        $display("test interrupt done");
        do_reset();
        chk(dxd, 0);
        wb(1, REG_CTRL, ctl(ID_CODE_4I4O, 0, 5'h05));
        m.xchg(0, r);
        no_wd();
        saddr <= 5'h05;
        n = wd_n;
        for (i = 0; i < 6; i++) begin
            m.xchg(i[0], r);
            kick = cyc;
            repeat (T - 15) @(posedge clk_i);
        end
        chk(wd_n, n);
        m.xchg(1'b1, r);
        exp_wd(kick);
        chk(dxd, 1);
        wb(0, REG_STATUS, 0);
        chk(rd, 32'h20);
        wb(0, REG_IRQ_STAT, 0);
        chk(rd, 32'h1);
        $display("test toggle done");
        do_reset();
        wb(1, REG_CTRL, ctl(4'h9, 0, 5'h05));
        m.xchg(0, r);
        no_wd();
        wb(1, REG_CTRL, ctl(ID_CODE_4I4O, 0, 5'h01));
        m.xchg(1, r);
        no_wd();
        wb(1, REG_CTRL, ctl(ID_CODE_4I4O, 0, 5'h05));
        m.del(r);
        no_wd();
        wb(1, REG_CTRL, ctl(ID_CODE_4I4O, 0, 5'h06));
        m.xchg(0, r);
        no_wd();
        p0 <= 1'b1;
        repeat (3) @(posedge clk_i);
        m.xchg(1, r);
        kick = cyc;
        exp_wd(kick);
        $display("test activation done");
        stop_test();
    end
endmodule
